/* src/equalizer_fir_a.sv */
// Functional notes
// [R1] nine-tap filter, fifth tap is centre, centre coefficient signed 18 bits
// [R2] centre coefficient in bits 17:0; bits 23:18 reserved, reset zero
// [R3] taps six to nine: signed 12-bit in bits 11:0; bits 15:12 reserved
// [R4] one coefficient set serves channel A or the single combined filter
// [R5] readback returns coefficient field msb as zero whatever was written
// [R6] tap six coefficient at 0x423, resets to zero
// [R7] taps seven, eight, nine at 0x425, 0x427, 0x429, reset zero
// [R8] centre tap coefficient at 0x420, resets to zero
// [R9] each output is sum of nine coefficients times nine newest samples
module equalizer_fir_a #(
   parameter int SAMPLE_W = equalizer_fir_pkg::SAMPLE_W,
   parameter int OUT_W    = equalizer_fir_pkg::OUT_W
) (
   input  wire logic                            clk,
   input  wire logic                            reset_n,
   input  wire equalizer_fir_pkg::reg_req_s     reg_req,
   output logic [7:0]                           reg_rdata,
   input  wire equalizer_fir_pkg::lower_taps_s  lower_taps,
   input  wire logic                            in_valid,
   output logic                                 in_ready,
   input  wire logic [SAMPLE_W-1:0]             in_sample,
   output logic                                 out_valid,
   input  wire logic                            out_ready,
   output logic [OUT_W-1:0]                     out_data
);
   localparam int NT = equalizer_fir_pkg::NUM_TAPS;
   localparam int NU = equalizer_fir_pkg::NUM_UPPER;
   localparam int CW = equalizer_fir_pkg::CENTRE_W;
   localparam int PW = SAMPLE_W + CW;

   logic [23:0]      centre_q;
   logic [15:0]      upper_q [NU];
   logic [7:0]       rdata_q;
   logic [SAMPLE_W-1:0] hist_q [NT-1];

   // address decode
   wire [15:0] a = reg_req.addr;
   wire c_b0 = (a == equalizer_fir_pkg::CENTRE_TAP_COEFF_A_OFS);              // [R8]
   wire c_b1 = (a == equalizer_fir_pkg::CENTRE_TAP_COEFF_A_OFS + 16'h0001);   // [R8]
   wire c_b2 = (a == equalizer_fir_pkg::CENTRE_TAP_COEFF_A_OFS + 16'h0002);   // [R8]
   logic [NU-1:0] u_lo;
   logic [NU-1:0] u_hi;

   // readback images with the coefficient msb forced low
   wire [23:0] centre_rd = {centre_q[23:18], 1'b0, centre_q[16:0]};          // [R5]
   logic [15:0] upper_rd [NU];

   genvar g;
   generate
      for (g = 0; g < NU; g++) begin : g_dec
         assign u_lo[g] = (a == equalizer_fir_pkg::UPPER_OFS[g]);                 // [R6] [R7]
         assign u_hi[g] = (a == equalizer_fir_pkg::UPPER_OFS[g] + 16'h0001);      // [R6] [R7]
         assign upper_rd[g] = {upper_q[g][15:12], 1'b0, upper_q[g][10:0]};        // [R5]
      end
   endgenerate

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (c_b0) rd_mux = centre_rd[7:0];
      if (c_b1) rd_mux = centre_rd[15:8];
      if (c_b2) rd_mux = centre_rd[23:16];
      for (int i = 0; i < NU; i++) begin
         if (u_lo[i]) rd_mux = upper_rd[i][7:0];
         if (u_hi[i]) rd_mux = upper_rd[i][15:8];
      end
   end

   // reserved bits are plain storage, so they read back what was written
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         centre_q <= equalizer_fir_pkg::CENTRE_TAP_RESET;                      // [R2] [R8]
         for (int i = 0; i < NU; i++) upper_q[i] <= equalizer_fir_pkg::TAP_RESET; // [R6] [R7]
      end else if (reg_req.we) begin
         if (c_b0) centre_q[7:0]   <= reg_req.wdata;
         if (c_b1) centre_q[15:8]  <= reg_req.wdata;
         if (c_b2) centre_q[23:16] <= reg_req.wdata;
         for (int i = 0; i < NU; i++) begin
            if (u_lo[i]) upper_q[i][7:0]  <= reg_req.wdata;
            if (u_hi[i]) upper_q[i][15:8] <= reg_req.wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) rdata_q <= equalizer_fir_pkg::RDATA_RESET;
      else if (reg_req.re) rdata_q <= rd_mux;
   end
   assign reg_rdata = rdata_q;

   // coefficient vector, the eight outer taps sign-extended to centre width
   logic signed [CW-1:0] coef [NT];
   generate
      for (g = 0; g < equalizer_fir_pkg::NUM_LOWER; g++) begin : g_low
         assign coef[g] = {{(CW-12){lower_taps.coeff[g][11]}}, lower_taps.coeff[g]};
      end
      for (g = 0; g < NU; g++) begin : g_up
         // same registers whether the filter runs per channel or combined
         assign coef[g+5] = {{(CW-12){upper_q[g][equalizer_fir_pkg::TAP_MSB]}},
                             upper_q[g][11:0]};                                 // [R3] [R4]
      end
   endgenerate
   assign coef[4] = centre_q[equalizer_fir_pkg::CENTRE_MSB:0];                  // [R1] [R2] [R4]

   // sample window: index 0 is the arriving sample, tap one
   logic signed [SAMPLE_W-1:0] win [NT];
   assign win[0] = in_sample;
   generate
      for (g = 1; g < NT; g++) begin : g_win
         assign win[g] = hist_q[g-1];
      end
   endgenerate

   logic signed [OUT_W-1:0] acc;
   always_comb begin
      logic signed [PW-1:0] prod;
      acc  = '0;
      prod = '0;
      for (int k = 0; k < NT; k++) begin
         prod = win[k] * coef[k];                                               // [R9]
         acc  = acc + {{(OUT_W-PW){prod[PW-1]}}, prod};                         // [R9]
      end
   end

   // a full buffer stalls the sample source, history only moves on accept
   wire take = in_valid && in_ready;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NT-1; i++) hist_q[i] <= '0;
      end else if (take) begin
         hist_q[0] <= in_sample;                                                // [R1]
         for (int i = 1; i < NT-1; i++) hist_q[i] <= hist_q[i-1];
      end
   end

   two_entry_buffer #(
      .WIDTH (OUT_W),
      .DEPTH (equalizer_fir_pkg::BUF_DEPTH)
   ) u_out_buf (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (acc),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );

endmodule : equalizer_fir_a

/* src/equalizer_fir_pkg.sv */
package equalizer_fir_pkg;

   localparam int SAMPLE_W     = 12;
   localparam int COEFF_W      = 12;
   localparam int CENTRE_W     = 18;
   localparam int CENTRE_REG_W = 24;
   localparam int TAP_REG_W    = 16;
   localparam int NUM_TAPS     = 9;
   localparam int NUM_LOWER    = 4;
   localparam int NUM_UPPER    = 4;
   localparam int ADDR_W       = 16;
   localparam int PROD_W       = SAMPLE_W + CENTRE_W;
   localparam int OUT_W        = PROD_W + 4;
   localparam int BUF_DEPTH    = 2;

   // field positions
   localparam int CENTRE_MSB   = 17;
   localparam int TAP_MSB      = 11;

   // byte addresses, lowest byte of each register holds bits 7:0
   localparam logic [15:0] CENTRE_TAP_COEFF_A_OFS = 16'h0420;
   localparam logic [15:0] TAP6_COEFF_A_OFS       = 16'h0423;
   localparam logic [15:0] TAP7_COEFF_A_OFS       = 16'h0425;
   localparam logic [15:0] TAP8_COEFF_A_OFS       = 16'h0427;
   localparam logic [15:0] TAP9_COEFF_A_OFS       = 16'h0429;
   localparam logic [3:0][15:0] UPPER_OFS = {TAP9_COEFF_A_OFS, TAP8_COEFF_A_OFS,
                                             TAP7_COEFF_A_OFS, TAP6_COEFF_A_OFS};

   localparam logic [23:0] CENTRE_TAP_RESET = 24'h000000;
   localparam logic [15:0] TAP_RESET        = 16'h0000;
   localparam logic [7:0]  RDATA_RESET      = 8'h00;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } reg_req_s;

   // taps one to four, held outside this block
   typedef struct packed {
      logic [3:0][11:0] coeff;
   } lower_taps_s;

endpackage : equalizer_fir_pkg

/* src/two_entry_buffer.sv */
module two_entry_buffer #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1);
   localparam logic [PW:0]   FULLC = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   wire [PW-1:0]     wr_nx = (wr_q == LAST) ? '0 : wr_q + 1'b1;
   wire [PW-1:0]     rd_nx = (rd_q == LAST) ? '0 : rd_q + 1'b1;

   assign in_ready  = (cnt_q != FULLC);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= wr_nx;
         end
         if (pop) rd_q <= rd_nx;
         if (push && !pop) cnt_q <= cnt_q + 1'b1;
         else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
   end

endmodule : two_entry_buffer

/* test/equalizer_fir_a_properties.sv */
module fir_coeff_checker #(
   parameter int OUT_W = equalizer_fir_pkg::OUT_W
) (
   input wire logic                        clk,
   input wire logic                        reset_n,
   input wire equalizer_fir_pkg::reg_req_s reg_req,
   input wire logic [7:0]                  reg_rdata,
   input wire logic                        in_valid,
   input wire logic                        in_ready,
   input wire logic                        out_valid,
   input wire logic                        out_ready,
   input wire logic [OUT_W-1:0]            out_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic [15:0] a  = reg_req.addr;
   wire logic [7:0]  wd = reg_req.wdata;
   wire logic        unmapped = a < 16'h0420 || a > 16'h042A;
   // read of the byte just written
   sequence wr_then_rd(logic hit);
      reg_req.we && hit ##1 reg_req.re && $stable(a);
   endsequence
   full_byte_back_a: assert property (
      wr_then_rd(a inside {16'h0420, 16'h0421, 16'h0423, 16'h0425, 16'h0427, 16'h0429})
      |=> reg_rdata == $past(wd, 2)) else $error("full byte readback wrong");
   centre_top_back_a: assert property (
      wr_then_rd(a == 16'h0422) |=> reg_rdata == ($past(wd, 2) & 8'hFD)) else $error("centre top byte wrong");
   tap_top_back_a: assert property (
      wr_then_rd(a inside {16'h0424, 16'h0426, 16'h0428, 16'h042A})
      |=> reg_rdata == ($past(wd, 2) & 8'hF7)) else $error("tap top byte wrong");
   unmapped_read_a: assert property (
      reg_req.re && unmapped |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_req.re |=> $stable(reg_rdata)) else $error("read data moved without read");
   push_valid_a: assert property (
      in_valid && in_ready |=> out_valid) else $error("taken sample gave no result");
   stall_hold_a: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("stalled result lost");
   room_empty_a: assert property (
      !out_valid |-> in_ready) else $error("empty buffer refused sample");
endmodule : fir_coeff_checker

bind equalizer_fir_a fir_coeff_checker #(.OUT_W(OUT_W)) u_chk (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
   .out_ready(out_ready), .out_data(out_data));

/* test/tb_equalizer_fir_a.sv */
module tb_equalizer_fir_a;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = equalizer_fir_pkg::OUT_W;
   logic                           clk = 1'b0;
   logic                           reset_n = 1'b0;
   equalizer_fir_pkg::reg_req_s    req = '0;
   equalizer_fir_pkg::lower_taps_s lt = '0;
   logic [7:0]                     rdata;
   logic                           in_valid = 1'b0, in_ready, out_valid, out_ready = 1'b0, rd_q = 1'b0, drain = 1'b0;
   logic [11:0]                    smp = '0;
   logic [W-1:0]                   out_data;
   logic [7:0]                     m [11] = '{default: '0};
   longint                         xs [9] = '{default: 0};
   logic [W-1:0]                   sq [$];
   logic [7:0]                     rq [$];
   int                             err_total = 0, n_checks = 0, seed = 25;
   always #20 clk = ~clk;
   equalizer_fir_a u_dut (.clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
      .lower_taps(lt), .in_valid(in_valid), .in_ready(in_ready), .in_sample(smp),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
   task automatic chk(string nm, logic [W-1:0] seen, logic [W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   function automatic longint cf(int k);
      int j = 3 + 2 * (k - 5);
      if (k < 4) return $signed(lt.coeff[k]);
      if (k == 4) return $signed({m[2][1:0], m[1], m[0]});
      return $signed({m[j + 1][3:0], m[j]});
   endfunction : cf
   // no strobe drop inside: back-to-back calls keep one assignment per step
   task automatic bus(logic [15:0] ad, logic [7:0] d, logic w);
      int i = ad - 16'h0420;
      logic ok = ad >= 16'h0420 && ad <= 16'h042A;
      req = '{addr: ad, wdata: d, we: w, re: !w};
      if (!w) rq.push_back(!ok ? 8'h00 : m[i] & (i == 2 ? 8'hFD : i >= 4 && i % 2 == 0 ? 8'hF7 : 8'hFF));
      @(negedge clk);
      if (w && ok) m[i] = d;
   endtask : bus
   task automatic push(logic [11:0] s);
      longint acc = 0;
      in_valid = 1'b1;
      smp = s;
      for (int t = 0; t < 50; t++) begin
         @(posedge clk);
         if (in_ready) break;
         if (t == 49) begin
            err_total++;
            wrap_up();
         end
      end
      for (int k = 8; k > 0; k--) xs[k] = xs[k - 1];
      xs[0] = $signed(s);
      for (int k = 0; k < 9; k++) acc += cf(k) * xs[k];
      sq.push_back(W'(acc));
      @(negedge clk);
   endtask : push
   always @(negedge clk) out_ready <= drain || ($random(seed) & 3) == 0;
   always @(posedge clk) begin
      if (rd_q) chk("reg_rdata", W'(rdata), W'(rq.pop_front()));
      if (out_valid && out_ready) chk("out_data", out_data, sq.pop_front());
      rd_q <= req.re;
   end
   initial begin
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      for (int a = 16'h041F; a <= 16'h042B; a++) bus(16'(a), 8'h00, 1'b0);
      $display("test reset values done");
      // unmapped neighbours written too, must stay invisible
      for (int a = 16'h041F; a <= 16'h042B; a++) begin
         bus(16'(a), 8'($random(seed)), 1'b1);
         bus(16'(a), 8'h00, 1'b0);
      end
      req.re = 1'b0;
      $display("test readback done");
      lt = 48'({$random(seed), $random(seed)});
      for (int n = 0; n < 30; n++) push(12'($random(seed)));
      in_valid = 1'b0;
      drain = 1'b1;
      for (int t = 0; t < 100 && sq.size() > 0; t++) @(negedge clk);
      if (sq.size() > 0) err_total++;
      $display("test stream done");
      wrap_up();
   end
endmodule : tb_equalizer_fir_a
